// ===== rtl/ospt_top.sv
// Run clock configuration register slice, translation register and Avalon-MM slave.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Crystal codes 0x00-0x16 name crystals; 0x00-0x03 give no PLL translation.
// - Crystal code resets to 0x0B, the 6 MHz crystal.
// - Oscillator source field sits at bits 5:4, read/write, resets to 1.
// - Source 0 main, 1 internal, 2 internal divided by four, 3 30 kHz.
// - Bit 1 set stops the internal oscillator; clear at reset keeps it running.
// - Bit 0 set stops the main oscillator; it is set at reset.
// - Reserved bits read as zero; software keeps them on read-modify-write.
// - Translation loads at reset and recomputes whenever the crystal code changes.
// - PLL frequency equals oscillator frequency times multiplier over divide plus one.
// - Translation bits 13:5 carry the multiplier driven to the PLL.
// - Translation bits 4:0 carry the reference divide driven to the PLL.
// - Crystal code lives in bits 10:6 of the run clock configuration word.
// - Bypass bit 11 set takes system ticks from the oscillator, not the PLL.
module ospt_top #(
	parameter int PRECISION_INTERNAL_OSC_DIV = ospt_pkg::OSPT_PRECISION_INTERNAL_OSC_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire ospt_pkg::ospt_avm_req_s avmReq,
	output logic [31:0] avmReadData,
	output logic avmWaitRequest,
	input wire logic mainOscTick,
	input wire logic pioscTick,
	input wire logic lfoscTick,
	input wire logic pllTick,
	output logic oscTick,
	output logic sysTick,
	output logic mainOscEn,
	output logic pioscEn,
	output ospt_pkg::ospt_xlat_s pllXlat
);
	import ospt_pkg::*;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		ospt_rcc_s run_clock_configuration;
	} ospt_tstate_s;

	ospt_tstate_s state_ff;
	ospt_tstate_s nxt_state;
	logic request;
	logic accept;
	logic hitRcc;
	logic hitXlat;
	logic [31:0] rccWord;
	logic [31:0] xlatWord;
	logic [31:0] merged;
	ospt_xlat_s xlat;

	// Packs the held fields into bus words; every other bit reads as zero.
	always_comb begin
		rccWord = '0;
		rccWord[OSPT_MAIN_OSCILLATOR_BIT] = state_ff.run_clock_configuration.mainOscDisable;
		rccWord[OSPT_IOSC_BIT] = state_ff.run_clock_configuration.internalOscDisable;
		rccWord[OSPT_SRC_LSB +: 2] = state_ff.run_clock_configuration.oscSrc;
		rccWord[OSPT_CRYSTAL_CODE_LSB +: OSPT_CRYSTAL_CODE_W] = state_ff.run_clock_configuration.crystalCode;
		rccWord[OSPT_BYPASS_BIT] = state_ff.run_clock_configuration.bypass;
		xlatWord = '0;
		xlatWord[OSPT_F_LSB +: OSPT_F_W] = xlat.mult;
		xlatWord[OSPT_R_LSB +: OSPT_R_W] = xlat.div;
	end

	// Address decode and the one-wait-state handshake.
	assign request = avmReq.read | avmReq.write;
	assign accept = request & state_ff.ack;
	assign hitRcc = avmReq.address == OSPT_RCC_OFFS;
	assign hitXlat = avmReq.address == OSPT_XLAT_OFFS;
	assign avmWaitRequest = request & ~state_ff.ack;
	assign merged = ospt_merge(rccWord, avmReq.writedata, avmReq.byteenable);

	// Next state: read data is fetched in the wait cycle, writes land on acceptance.
	always_comb begin
		nxt_state = state_ff;
		nxt_state.ack = request & ~state_ff.ack;
		if (request && !state_ff.ack) begin
			nxt_state.rdata = hitRcc ? rccWord : (hitXlat ? xlatWord : '0);
		end
		if (accept && avmReq.write && hitRcc) begin
			nxt_state.run_clock_configuration.mainOscDisable = merged[OSPT_MAIN_OSCILLATOR_BIT];
			nxt_state.run_clock_configuration.internalOscDisable = merged[OSPT_IOSC_BIT];
			nxt_state.run_clock_configuration.oscSrc = ospt_src_e'(merged[OSPT_SRC_LSB +: 2]);
			nxt_state.run_clock_configuration.crystalCode = merged[OSPT_CRYSTAL_CODE_LSB +: OSPT_CRYSTAL_CODE_W];
			nxt_state.run_clock_configuration.bypass = merged[OSPT_BYPASS_BIT];
		end
	end

	// Registers the slave state; configuration takes its reset defaults.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '{ack: 1'b0, rdata: '0, run_clock_configuration: OSPT_RCC_RST};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign avmReadData = state_ff.rdata;
	assign pllXlat = xlat;

	// Translation of the crystal code.
	ospt_xlate u_xlate (
		.clk(clk),
		.rst_n(rst_n),
		.crystalCode(state_ff.run_clock_configuration.crystalCode),
		.xlat(xlat)
	);

	// Oscillator gating and routing.
	ospt_src_mux #(
		.PRECISION_INTERNAL_OSC_DIV(PRECISION_INTERNAL_OSC_DIV)
	) u_src_mux (
		.clk(clk),
		.rst_n(rst_n),
		.run_clock_configuration(state_ff.run_clock_configuration),
		.mainOscTick(mainOscTick),
		.pioscTick(pioscTick),
		.lfoscTick(lfoscTick),
		.pllTick(pllTick),
		.oscTick(oscTick),
		.sysTick(sysTick),
		.mainOscEn(mainOscEn),
		.pioscEn(pioscEn)
	);

	// Marks the first cycle after reset release for the reset-value check.
	logic rstSeen_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSeen_ff <= 1'b0;
		end else begin
			rstSeen_ff <= 1'b1;
		end
	end

	// Configuration and translation hold their defaults right after reset.
	property p_reset_values;
		@(posedge clk) disable iff (!rst_n)
		!rstSeen_ff |-> (state_ff.run_clock_configuration.crystalCode == 5'h0B) && (state_ff.run_clock_configuration.oscSrc == OSPT_SRC_PRECISION_INTERNAL_OSC)
			&& state_ff.run_clock_configuration.mainOscDisable && !state_ff.run_clock_configuration.internalOscDisable
			&& (xlat == OSPT_XLAT_RST);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset defaults wrong");

	// An accepted full write to the configuration word updates the crystal code.
	property p_code_write;
		@(posedge clk) disable iff (!rst_n)
		(accept && avmReq.write && hitRcc && avmReq.byteenable == 4'hF)
			|=> state_ff.run_clock_configuration.crystalCode == $past(avmReq.writedata[10:6]);
	endproperty
	a_code_write: assert property (p_code_write) else $error("crystal code not written");

	// Source field follows a full write to bits 5:4.
	property p_src_write;
		@(posedge clk) disable iff (!rst_n)
		(accept && avmReq.write && hitRcc && avmReq.byteenable[0])
			|=> state_ff.run_clock_configuration.oscSrc == $past(avmReq.writedata[5:4]);
	endproperty
	a_src_write: assert property (p_src_write) else $error("source field not written");

	// A crystal code change is followed by its translation one cycle later.
	property p_recompute;
		@(posedge clk) disable iff (!rst_n)
		$changed(state_ff.run_clock_configuration.crystalCode) |=> xlat == ospt_lookup($past(state_ff.run_clock_configuration.crystalCode));
	endproperty
	a_recompute: assert property (p_recompute) else $error("translation not recomputed");

	// Reserved codes below the PLL range (0x00-0x03) give an all-zero translation once settled.
	property p_reserved_code;
		@(posedge clk) disable iff (!rst_n)
		(state_ff.run_clock_configuration.crystalCode < OSPT_CRYSTAL_CODE_PLL_MIN) ##1 $stable(state_ff.run_clock_configuration.crystalCode)
			|-> xlat == '0;
	endproperty
	a_reserved_code: assert property (p_reserved_code) else $error("reserved code translated");

	// Reads of the configuration word show zeros in every reserved bit.
	property p_rcc_reserved;
		@(posedge clk) disable iff (!rst_n)
		(accept && avmReq.read && hitRcc) |-> (avmReadData[3:2] == 2'h0) && (avmReadData[31:12] == '0);
	endproperty
	a_rcc_reserved: assert property (p_rcc_reserved) else $error("reserved bits not zero");

	// A translation read returns the multiplier and divide on the PLL port.
	property p_xlat_read;
		@(posedge clk) disable iff (!rst_n)
		(accept && avmReq.read && hitXlat) |-> (avmReadData[13:5] == pllXlat.mult)
			&& (avmReadData[4:0] == pllXlat.div) && (avmReadData[31:14] == '0);
	endproperty
	a_xlat_read: assert property (p_xlat_read) else $error("translation read mismatch");

	// A write aimed at the translation register changes nothing.
	property p_xlat_ro;
		@(posedge clk) disable iff (!rst_n)
		(accept && avmReq.write && hitXlat) |=> $stable(xlat) && $stable(state_ff.run_clock_configuration);
	endproperty
	a_xlat_ro: assert property (p_xlat_ro) else $error("translation write took effect");

	// Oscillator enables follow the disable bits within one cycle.
	property p_osc_enables;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (mainOscEn == !$past(state_ff.run_clock_configuration.mainOscDisable))
			&& (pioscEn == !$past(state_ff.run_clock_configuration.internalOscDisable));
	endproperty
	a_osc_enables: assert property (p_osc_enables) else $error("oscillator enable wrong");

	// While the internal tick is low, a stopped main oscillator never reaches the source tick.
	property p_main_stopped;
		@(posedge clk) disable iff (!rst_n)
		(state_ff.run_clock_configuration.oscSrc == OSPT_SRC_MAIN && state_ff.run_clock_configuration.mainOscDisable && !pioscTick)
			|=> !oscTick;
	endproperty
	a_main_stopped: assert property (p_main_stopped) else $error("stopped oscillator ticked");

	// Selected main oscillator ticks pass through one cycle later.
	property p_route_main;
		@(posedge clk) disable iff (!rst_n)
		(state_ff.run_clock_configuration.oscSrc == OSPT_SRC_MAIN && !state_ff.run_clock_configuration.mainOscDisable && mainOscTick)
			|=> oscTick;
	endproperty
	a_route_main: assert property (p_route_main) else $error("main source not routed");

	// Without bypass the system tick is the PLL tick.
	property p_pll_path;
		@(posedge clk) disable iff (!rst_n)
		!state_ff.run_clock_configuration.bypass |=> sysTick == $past(pllTick);
	endproperty
	a_pll_path: assert property (p_pll_path) else $error("PLL path wrong");

	// With bypass the system tick equals the oscillator tick.
	property p_bypass_path;
		@(posedge clk) disable iff (!rst_n)
		$past(state_ff.run_clock_configuration.bypass) |-> sysTick == oscTick;
	endproperty
	a_bypass_path: assert property (p_bypass_path) else $error("bypass path wrong");

	// The bus answers one cycle after the request is raised.
	property p_one_wait;
		@(posedge clk) disable iff (!rst_n)
		($rose(request) || (request && $past(accept))) |-> avmWaitRequest ##1 !avmWaitRequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");

	// Main scenarios.
	c_code_change: cover property (@(posedge clk) disable iff (!rst_n)
		$changed(state_ff.run_clock_configuration.crystalCode) ##1 $changed(xlat));
	c_div4_route: cover property (@(posedge clk) disable iff (!rst_n)
		state_ff.run_clock_configuration.oscSrc == OSPT_SRC_PRECISION_INTERNAL_OSC_DIV4 && oscTick);
	c_pll_sys: cover property (@(posedge clk) disable iff (!rst_n)
		!state_ff.run_clock_configuration.bypass && sysTick);
	c_xlat_read: cover property (@(posedge clk) disable iff (!rst_n)
		accept && avmReq.read && hitXlat);
endmodule
`default_nettype wire

// ===== rtl/ospt_pkg.sv
// Shared constants, types and lookup for the oscillator select and PLL translation block.
package ospt_pkg;

	// Bus geometry.
	localparam int OSPT_ADDR_W = 12;
	localparam logic [11:0] OSPT_RCC_OFFS = 12'h060;
	localparam logic [11:0] OSPT_XLAT_OFFS = 12'h064;

	// Field positions in the run clock configuration word.
	localparam int OSPT_MAIN_OSCILLATOR_BIT = 0;
	localparam int OSPT_IOSC_BIT = 1;
	localparam int OSPT_SRC_LSB = 4;
	localparam int OSPT_CRYSTAL_CODE_LSB = 6;
	localparam int OSPT_BYPASS_BIT = 11;
	localparam int OSPT_CRYSTAL_CODE_W = 5;

	// Field positions and widths in the translation word.
	localparam int OSPT_R_LSB = 0;
	localparam int OSPT_F_LSB = 5;
	localparam int OSPT_F_W = 9;
	localparam int OSPT_R_W = 5;

	// Crystal code limits.
	localparam logic [4:0] OSPT_CRYSTAL_CODE_MAX = 5'h16;
	localparam logic [4:0] OSPT_CRYSTAL_CODE_PLL_MIN = 5'h04;

	// Oscillator source encodings.
	typedef enum logic [1:0] {
		OSPT_SRC_MAIN = 2'h0,
		OSPT_SRC_PRECISION_INTERNAL_OSC = 2'h1,
		OSPT_SRC_PRECISION_INTERNAL_OSC_DIV4 = 2'h2,
		OSPT_SRC_LFOSC = 2'h3
	} ospt_src_e;

	// Held fields of the run clock configuration register.
	typedef struct packed {
		logic bypass;
		logic [OSPT_CRYSTAL_CODE_W-1:0] crystalCode;
		ospt_src_e oscSrc;
		logic internalOscDisable;
		logic mainOscDisable;
	} ospt_rcc_s;

	// PLL multiplier and reference divide.
	typedef struct packed {
		logic [OSPT_F_W-1:0] mult;
		logic [OSPT_R_W-1:0] div;
	} ospt_xlat_s;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic read;
		logic write;
		logic [OSPT_ADDR_W-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} ospt_avm_req_s;

	// Reset values.
	localparam ospt_rcc_s OSPT_RCC_RST = '{bypass: 1'b1, crystalCode: 5'h0B,
		oscSrc: OSPT_SRC_PRECISION_INTERNAL_OSC, internalOscDisable: 1'b0, mainOscDisable: 1'b1};
	localparam int OSPT_PRECISION_INTERNAL_OSC_DIV = 4;

	// Multiplier and divide per crystal code, aiming at a 400 MHz PLL output.
	localparam ospt_xlat_s OSPT_XLAT_TBL [0:22] = '{
		'{9'h000, 5'h00}, '{9'h000, 5'h00}, '{9'h000, 5'h00}, '{9'h000, 5'h00},
		'{9'h14F, 5'h02}, '{9'h146, 5'h02}, '{9'h190, 5'h03}, '{9'h187, 5'h03},
		'{9'h197, 5'h04}, '{9'h190, 5'h04}, '{9'h187, 5'h04}, '{9'h190, 5'h05},
		'{9'h187, 5'h05}, '{9'h17C, 5'h06}, '{9'h190, 5'h07}, '{9'h187, 5'h07},
		'{9'h190, 5'h09}, '{9'h190, 5'h0B}, '{9'h187, 5'h0B}, '{9'h17F, 5'h0C},
		'{9'h187, 5'h0D}, '{9'h190, 5'h0F}, '{9'h187, 5'h0F}};

	// Translation of one crystal code; reserved and unknown codes give zero.
	function automatic ospt_xlat_s ospt_lookup(input logic [OSPT_CRYSTAL_CODE_W-1:0] code);
		if (code > OSPT_CRYSTAL_CODE_MAX || code < OSPT_CRYSTAL_CODE_PLL_MIN) begin
			return '0;
		end
		return OSPT_XLAT_TBL[code];
	endfunction

	localparam ospt_xlat_s OSPT_XLAT_RST = OSPT_XLAT_TBL[5'h0B];

	// Merges write data into an old word under the byte enables.
	function automatic logic [31:0] ospt_merge(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return res;
	endfunction

endpackage

// ===== rtl/ospt_xlate.sv
// Translation register that follows the crystal code.
`timescale 1ns/1ps
`default_nettype none
module ospt_xlate (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ospt_pkg::OSPT_CRYSTAL_CODE_W-1:0] crystalCode,
	output ospt_pkg::ospt_xlat_s xlat
);
	import ospt_pkg::*;

	typedef struct packed {
		logic [OSPT_CRYSTAL_CODE_W-1:0] lastCode;
		ospt_xlat_s xlat;
	} ospt_xstate_s;

	ospt_xstate_s state_ff;
	ospt_xstate_s nxt_state;

	// Recomputes the translation only when the crystal code moves.
	always_comb begin
		nxt_state = state_ff;
		if (crystalCode != state_ff.lastCode) begin
			nxt_state.lastCode = crystalCode;
			nxt_state.xlat = ospt_lookup(crystalCode);
		end
	end

	// The reset sequence loads the translation of the reset crystal code.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '{lastCode: OSPT_RCC_RST.crystalCode, xlat: OSPT_XLAT_RST};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign xlat = state_ff.xlat;
endmodule
`default_nettype wire

// ===== rtl/ospt_src_mux.sv
// Oscillator gating, source routing and bypass selection on tick enables.
`timescale 1ns/1ps
`default_nettype none
module ospt_src_mux #(
	parameter int PRECISION_INTERNAL_OSC_DIV = ospt_pkg::OSPT_PRECISION_INTERNAL_OSC_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire ospt_pkg::ospt_rcc_s run_clock_configuration,
	input wire logic mainOscTick,
	input wire logic pioscTick,
	input wire logic lfoscTick,
	input wire logic pllTick,
	output logic oscTick,
	output logic sysTick,
	output logic mainOscEn,
	output logic pioscEn
);
	import ospt_pkg::*;

	localparam int CNT_W = $clog2(PRECISION_INTERNAL_OSC_DIV);

	if (PRECISION_INTERNAL_OSC_DIV < 2) begin : g_chk
		$error("PRECISION_INTERNAL_OSC_DIV must be at least 2");
	end

	typedef struct packed {
		logic [CNT_W-1:0] divCnt;
		logic oscTick;
		logic sysTick;
		logic mainEn;
		logic pioscEn;
	} ospt_mstate_s;

	ospt_mstate_s state_ff;
	ospt_mstate_s nxt_state;
	logic mainGated;
	logic pioscGated;
	logic pioscDivTick;
	logic srcTick;

	// Gates the main and internal oscillators, divides the internal one and routes the chosen source.
	always_comb begin
		nxt_state = state_ff;
		mainGated = mainOscTick & ~run_clock_configuration.mainOscDisable;
		pioscGated = pioscTick & ~run_clock_configuration.internalOscDisable;
		pioscDivTick = pioscGated && (state_ff.divCnt == CNT_W'(PRECISION_INTERNAL_OSC_DIV - 1));
		if (pioscGated) begin
			nxt_state.divCnt = pioscDivTick ? '0 : state_ff.divCnt + 1'b1;
		end
		case (run_clock_configuration.oscSrc)
			OSPT_SRC_MAIN: srcTick = mainGated;
			OSPT_SRC_PRECISION_INTERNAL_OSC: srcTick = pioscGated;
			OSPT_SRC_PRECISION_INTERNAL_OSC_DIV4: srcTick = pioscDivTick;
			OSPT_SRC_LFOSC: srcTick = lfoscTick;
			default: srcTick = 1'b0;
		endcase
		nxt_state.oscTick = srcTick;
		nxt_state.sysTick = run_clock_configuration.bypass ? srcTick : pllTick;
		nxt_state.mainEn = ~run_clock_configuration.mainOscDisable;
		nxt_state.pioscEn = ~run_clock_configuration.internalOscDisable;
	end

	// Registers the routing state; the main oscillator starts stopped.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '{divCnt: '0, oscTick: 1'b0, sysTick: 1'b0, mainEn: 1'b0,
				pioscEn: 1'b1};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign oscTick = state_ff.oscTick;
	assign sysTick = state_ff.sysTick;
	assign mainOscEn = state_ff.mainEn;
	assign pioscEn = state_ff.pioscEn;
endmodule
`default_nettype wire

// ===== verification/test_ospt_top.sv
// Self-checking testbench for the oscillator select and PLL translation block.
`timescale 1ns/1ps
`default_nettype none
module test_ospt_top;
	import ospt_pkg::*;

	logic clk;
	logic rst_n;
	ospt_avm_req_s avmReq;
	logic [31:0] avmReadData;
	logic avmWaitRequest;
	logic [3:0] tick;
	logic oscTick;
	logic sysTick;
	logic mainOscEn;
	logic pioscEn;
	ospt_xlat_s pllXlat;
	int fails;
	int samplesChecked;
	int cycles;
	int oscCnt;
	int sysCnt;
	logic [31:0] rd;

	ospt_top dut (
		.clk(clk),
		.rst_n(rst_n),
		.avmReq(avmReq),
		.avmReadData(avmReadData),
		.avmWaitRequest(avmWaitRequest),
		.mainOscTick(tick[0]),
		.pioscTick(tick[1]),
		.lfoscTick(tick[2]),
		.pllTick(tick[3]),
		.oscTick(oscTick),
		.sysTick(sysTick),
		.mainOscEn(mainOscEn),
		.pioscEn(pioscEn),
		.pllXlat(pllXlat)
	);

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Counts output tick pulses mid-cycle, where they are settled, and cuts a hung run short.
	always @(negedge clk) begin
		cycles++;
		if (oscTick === 1'b1) oscCnt++;
		if (sysTick === 1'b1) sysCnt++;
		if (cycles == 20000) begin
			fails++;
			$display("Error at %0t: run timed out", $time);
			reportAndStop();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic reportAndStop();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		samplesChecked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// One Avalon-MM access, held until waitrequest is seen low; the slave inserts one wait state.
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		@(posedge clk);
		avmReq.read <= ~wr;
		avmReq.write <= wr;
		avmReq.address <= a;
		avmReq.writedata <= d;
		avmReq.byteenable <= be;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (avmWaitRequest !== 1'b0);
		@(posedge clk);
		q = avmReadData;
		avmReq.read <= 1'b0;
		avmReq.write <= 1'b0;
		check(32'(n), 32'h0000_0002, "bus answer");
	endtask

	// Builds the expected configuration word from its fields.
	function automatic logic [31:0] cfgWord(input logic byp, input logic [1:0] src,
		input logic iosc, input logic main_oscillator, input logic [4:0] crystal_code);
		return (32'(byp) << OSPT_BYPASS_BIT) | (32'(crystal_code) << OSPT_CRYSTAL_CODE_LSB) |
			(32'(src) << OSPT_SRC_LSB) | (32'(iosc) << OSPT_IOSC_BIT) | 32'(main_oscillator);
	endfunction

	// Pulses one tick input n times and reports the output pulses seen.
	task automatic pulses(input int k, input int n, output int o, output int s);
		int o0;
		int s0;
		o0 = oscCnt;
		s0 = sysCnt;
		repeat (n) begin
			@(posedge clk);
			tick[k] <= 1'b1;
			@(posedge clk);
			tick[k] <= 1'b0;
		end
		repeat (3) @(posedge clk);
		o = oscCnt - o0;
		s = sysCnt - s0;
	endtask

	// Reset values of both registers and of the enables.
	task automatic scenario_reset();
		bus(1'b0, OSPT_RCC_OFFS, 32'h0, 4'hF, rd);
		check(rd, 32'h0000_0AD1, "config after reset");
		bus(1'b0, OSPT_XLAT_OFFS, 32'h0, 4'hF, rd);
		check(rd, 32'h0000_3205, "translation after reset");
		check(32'(pllXlat), 32'h0000_3205, "translation port after reset");
		check({30'h0, mainOscEn, pioscEn}, 32'h0000_0001, "enables after reset");
	endtask

	// Every crystal code, with all reserved bits written as ones.
	task automatic scenario_crystal_code();
		logic [31:0] w;
		logic [31:0] x;
		for (int c = 0; c <= 22; c++) begin
			w = cfgWord(1'b1, 2'h1, 1'b0, 1'b1, 5'(c));
			bus(1'b1, OSPT_RCC_OFFS, w | 32'hFFFF_F00C, 4'hF, rd);
			bus(1'b0, OSPT_RCC_OFFS, 32'h0, 4'hF, rd);
			check(rd, w, "config readback");
			x = (c < 4) ? 32'h0 : 32'(OSPT_XLAT_TBL[c]);
			bus(1'b0, OSPT_XLAT_OFFS, 32'h0, 4'hF, rd);
			check(rd, x, "translation per code");
			check(32'(pllXlat), x, "translation port per code");
		end
	endtask

	// Writes to the translation register and to an unmapped place change nothing.
	task automatic scenario_refused();
		bus(1'b1, OSPT_XLAT_OFFS, 32'hFFFF_FFFF, 4'hF, rd);
		bus(1'b0, OSPT_XLAT_OFFS, 32'h0, 4'hF, rd);
		check(rd, 32'(OSPT_XLAT_TBL[22]), "translation after write");
		bus(1'b1, 12'h0A0, 32'hFFFF_FFFF, 4'hF, rd);
		bus(1'b0, 12'h0A0, 32'h0, 4'hF, rd);
		check(rd, 32'h0, "unmapped read");
		bus(1'b0, OSPT_RCC_OFFS, 32'h0, 4'hF, rd);
		check(rd, cfgWord(1'b1, 2'h1, 1'b0, 1'b1, 5'h16), "config after stray writes");
		// Lane 0 only: source and disables clear, crystal bits 10:8 and bypass stay.
		bus(1'b1, OSPT_RCC_OFFS, 32'h0, 4'h1, rd);
		bus(1'b0, OSPT_RCC_OFFS, 32'h0, 4'hF, rd);
		check(rd, cfgWord(1'b1, 2'h0, 1'b0, 1'b0, 5'h14), "lane write");
	endtask

	// Source routing, bypass and oscillator gating seen at the tick outputs.
	task automatic scenario_routing();
		int o;
		int s;
		int e;
		for (int src = 0; src < 4; src++) begin
			bus(1'b1, OSPT_RCC_OFFS, cfgWord(1'b1, 2'(src), 1'b0, 1'b0, 5'h0B), 4'hF, rd);
			for (int k = 0; k < 3; k++) begin
				pulses(k, 8, o, s);
				e = ((src == 0 && k == 0) || (src == 1 && k == 1) || (src == 3 && k == 2)) ? 8 : 0;
				if (src == 2 && k == 1) e = 2;
				check(32'(o), 32'(e), "routed ticks");
				check(32'(s), 32'(e), "bypassed system ticks");
			end
		end
		bus(1'b1, OSPT_RCC_OFFS, cfgWord(1'b0, 2'h1, 1'b0, 1'b0, 5'h0B), 4'hF, rd);
		pulses(3, 8, o, s);
		check(32'(s), 32'h0000_0008, "pll system ticks");
		check(32'(o), 32'h0, "pll ticks not routed");
		bus(1'b1, OSPT_RCC_OFFS, cfgWord(1'b1, 2'h1, 1'b1, 1'b1, 5'h0B), 4'hF, rd);
		pulses(1, 8, o, s);
		check(32'(o), 32'h0, "stopped internal ticks");
		check({30'h0, mainOscEn, pioscEn}, 32'h0, "both stopped");
		bus(1'b1, OSPT_RCC_OFFS, cfgWord(1'b1, 2'h0, 1'b0, 1'b1, 5'h0B), 4'hF, rd);
		pulses(0, 8, o, s);
		check(32'(o), 32'h0, "stopped main ticks");
		bus(1'b1, OSPT_RCC_OFFS, cfgWord(1'b1, 2'h0, 1'b0, 1'b0, 5'h0B), 4'hF, rd);
		repeat (2) @(posedge clk);
		check({30'h0, mainOscEn, pioscEn}, 32'h0000_0003, "both running");
	endtask

	// A second reset in mid-run restores every default.
	task automatic scenario_rereset();
		bus(1'b1, OSPT_RCC_OFFS, cfgWord(1'b0, 2'h3, 1'b1, 1'b0, 5'h10), 4'hF, rd);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		scenario_reset();
	endtask

	// Main sequence.
	initial begin
		rst_n = 1'b0;
		avmReq = '0;
		tick = '0;
		fails = 0;
		samplesChecked = 0;
		cycles = 0;
		oscCnt = 0;
		sysCnt = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		scenario_reset();
		scenario_crystal_code();
		scenario_refused();
		scenario_routing();
		scenario_rereset();
		reportAndStop();
	end
endmodule
`default_nettype wire
